// >>> core/pse_pkg.sv
`default_nettype none
package pse_pkg;
    // ****************
    // Register map
    // ****************
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] THRESH_OFF = 8'h08;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int ST_POWER_BIT = 0;
    localparam int ST_MID_BIT = 1;
    localparam int ST_LEG_BIT = 2;
    localparam int ST_DUAL_BIT = 3;
    localparam int ST_LVL_LSB = 4;
    localparam int ST_CLS_LSB = 8;
    localparam int ST_DET_LSB = 12;
    localparam int ST_STATE_LSB = 16;
    localparam int ST_HOLD_BIT = 20;
    localparam int TH_CUT_LSB = 0;
    localparam int TH_LIM_LSB = 10;
    localparam int TH_DISC_LSB = 20;
    // ****************
    // Timing
    // ****************
    localparam int CLK_PERIOD_NS = 20;
    localparam int RST_FILTER_NS = 4500;
    localparam int RST_FILTER_CYC =
        (RST_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ****************
    // Detection
    // ****************
    localparam logic [2:0] DET_UNKNOWN = 3'h0;
    localparam logic [2:0] DET_SHORT = 3'h1;
    localparam logic [2:0] DET_CAP_HIGH = 3'h2;
    localparam logic [2:0] DET_RES_LOW = 3'h3;
    localparam logic [2:0] DET_GOOD = 3'h4;
    localparam logic [2:0] DET_RES_HIGH = 3'h5;
    localparam logic [2:0] DET_OPEN = 3'h6;
    localparam logic [2:0] DET_VOLT_OUT = 3'h7;
    localparam logic [15:0] R_SHORT_MAX = 16'h0960;
    localparam logic [15:0] R_GOOD_MIN = 16'h4268;
    localparam logic [15:0] R_GOOD_MAX = 16'h7148;
    localparam logic [15:0] R_OPEN_MIN = 16'hc350;
    // ****************
    // Power levels and thresholds
    // ****************
    localparam logic [2:0] LVL_13W = 3'h0;
    localparam logic [2:0] LVL_25W = 3'h1;
    localparam logic [2:0] LVL_CUSTOM = 3'h6;
    localparam logic [2:0] CLS_0 = 3'h0;
    localparam logic [2:0] CLS_3 = 3'h3;
    localparam logic [2:0] CLS_4 = 3'h4;
    localparam logic [8:0] CUT_CLS_LOW = 9'h040;
    localparam logic [8:0] CUT_CLS_4 = 9'h0a0;
    localparam logic [8:0] CUT_CUSTOM = 9'h100;
    localparam logic [8:0] LIM_CLS_LOW = 9'h060;
    localparam logic [8:0] LIM_CLS_4 = 9'h0d0;
    localparam logic [8:0] LIM_CUSTOM = 9'h180;
    localparam logic [9:0] DISC_CLS_4 = 10'h008;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_DETECT = 4'h2,
        ST_CLASSIFY = 4'h4,
        ST_POWERED = 4'h8
    } port_state_t;
endpackage : pse_pkg
`default_nettype wire

// >>> core/pse_ctrl.sv
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Latch strap inputs when reset releases
// - Reset at power-up and pin low
// - Later strap changes ignored until reset
// - Seven power levels in ascending order
// - Lowest level: single event, class 4 as 0
// - Higher levels act as full Type 2 source
// - Custom mode powers all, enhanced limits
// - Dual load doubles cutoff and limit
// - Dual load keeps normal disconnect value
// - Dual mode sees parallel signatures jointly
// - Thresholds from level and class result
// - Cutoff or limit fault removes power
// - Disconnect turns port power off
// - Unknown, then short, capacitance high, low, good
// - High, open, voltage out range
// - Good detection advances to classification
// - Legacy accepts cap, low, good, high
// - Legacy classes 0 to 3 get class 0
// - Without legacy or dual only good is valid
// - Dual mode passes resistance-low to class
// - Midspan strap enables midspan timing
// - Reset pin lows under 4.5us ignored
// - Powered indicator pulled low when powered
module pse_ctrl (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic reset_pin_n,
    input wire logic midspan_select,
    input wire logic legacy_select,
    input wire logic two_signature_select,
    input wire logic [2:0] power_level_select,
    input wire logic meas_done,
    input wire logic [15:0] signature_resistance,
    input wire logic load_capacitance_high,
    input wire logic port_voltage_high,
    input wire logic class_done,
    input wire logic [2:0] class_result,
    input wire logic fault_cutoff,
    input wire logic fault_limit,
    input wire logic load_disconnect,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic port_power_on,
    output logic second_event_enable,
    output logic midspan_timing,
    output logic [8:0] overcurrent_cutoff_threshold,
    output logic [8:0] current_limit_threshold,
    output logic [9:0] disconnect_threshold,
    output logic led_out,
    output logic led_oe
);
    // ****************
    // Functions
    // ****************
    function automatic logic [2:0] sort_det(
        input logic [15:0] r, input logic cap, input logic volt);
        logic [2:0] d;
        if (volt) d = pse_pkg::DET_VOLT_OUT;
        else if (cap) d = pse_pkg::DET_CAP_HIGH;
        else if (r < pse_pkg::R_SHORT_MAX) d = pse_pkg::DET_SHORT;
        else if (r < pse_pkg::R_GOOD_MIN) d = pse_pkg::DET_RES_LOW;
        else if (r <= pse_pkg::R_GOOD_MAX) d = pse_pkg::DET_GOOD;
        else if (r <= pse_pkg::R_OPEN_MIN) d = pse_pkg::DET_RES_HIGH;
        else d = pse_pkg::DET_OPEN;
        return d;
    endfunction : sort_det

    function automatic logic det_ok(
        input logic [2:0] d, input logic leg, input logic dual);
        logic ok;
        ok = (d == pse_pkg::DET_GOOD);
        if (leg && (d == pse_pkg::DET_CAP_HIGH ||
                    d == pse_pkg::DET_RES_LOW ||
                    d == pse_pkg::DET_RES_HIGH))
            ok = 1'b1;
        if (dual && d == pse_pkg::DET_RES_LOW)
            ok = 1'b1;
        return ok;
    endfunction : det_ok

    function automatic logic [8:0] pick_thr(
        input logic [2:0] cls, input logic [2:0] lvl,
        input logic dual, input logic [8:0] lo, input logic [8:0] hi,
        input logic [8:0] cust);
        logic [8:0] t;
        if (dual) t = {hi[7:0], 1'b0};
        else if (lvl == pse_pkg::LVL_CUSTOM) t = cust;
        else if (cls == pse_pkg::CLS_4) t = hi;
        else t = lo;
        return t;
    endfunction : pick_thr

    // ****************
    // Reset pin filter
    // ****************
    logic [7:0] low_cnt_reg, low_cnt_next;
    logic hold_reg, hold_next;
    logic cfg_load_reg, cfg_load_next;
    localparam logic [7:0] FILT_LAST =
        8'(pse_pkg::RST_FILTER_CYC - 1);

    always_comb begin
        low_cnt_next = low_cnt_reg;
        hold_next = hold_reg;
        cfg_load_next = cfg_load_reg;
        if (reset_pin_n) begin
            low_cnt_next = 8'h00;
            hold_next = 1'b0;
        end else if (low_cnt_reg >= FILT_LAST) begin
            hold_next = 1'b1;
        end else begin
            low_cnt_next = low_cnt_reg + 8'h01;
        end
        if (hold_reg) cfg_load_next = 1'b1;
        else if (cfg_load_reg) cfg_load_next = 1'b0;
    end

    // Straps are caught on the first clock after rst_n release, the second after the reset pin rises, never under reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt_reg <= 8'h00;
            hold_reg <= 1'b0;
            cfg_load_reg <= 1'b1;
        end else if (ce) begin
            low_cnt_reg <= low_cnt_next;
            hold_reg <= hold_next;
            cfg_load_reg <= cfg_load_next;
        end
    end

    // ****************
    // Strap latch
    // ****************
    logic mid_reg, mid_next, leg_reg, leg_next, dual_reg, dual_next;
    logic [2:0] lvl_reg, lvl_next;

    always_comb begin
        mid_next = mid_reg;
        leg_next = leg_reg;
        dual_next = dual_reg;
        lvl_next = lvl_reg;
        if (cfg_load_reg && !hold_reg) begin
            mid_next = midspan_select;
            leg_next = legacy_select;
            dual_next = two_signature_select;
            // Codes above custom are clamped to custom
            lvl_next = (power_level_select > pse_pkg::LVL_CUSTOM) ?
                pse_pkg::LVL_CUSTOM : power_level_select;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mid_reg <= 1'b0;
            leg_reg <= 1'b0;
            dual_reg <= 1'b0;
            lvl_reg <= pse_pkg::LVL_13W;
        end else if (ce) begin
            mid_reg <= mid_next;
            leg_reg <= leg_next;
            dual_reg <= dual_next;
            lvl_reg <= lvl_next;
        end
    end

    // ****************
    // Port sequencing
    // ****************
    pse_pkg::port_state_t state_reg, state_next;
    logic [2:0] det_reg, det_next, cls_reg, cls_next;
    logic dual_load_reg, dual_load_next;
    logic pwr_reg, pwr_next, sec_reg, sec_next;
    logic [8:0] cut_reg, cut_next, lim_reg, lim_next;
    logic [9:0] disc_reg, disc_next;
    logic en_reg, en_next;
    logic [2:0] det_now, cls_eff;
    logic run;

    assign run = en_reg && !hold_reg && !cfg_load_reg;
    assign det_now = sort_det(signature_resistance,
        load_capacitance_high, port_voltage_high);

    always_comb begin
        cls_eff = class_result;
        if (lvl_reg == pse_pkg::LVL_13W && class_result == pse_pkg::CLS_4)
            cls_eff = pse_pkg::CLS_0;
        if (leg_reg && class_result <= pse_pkg::CLS_3)
            cls_eff = pse_pkg::CLS_0;
    end

    always_comb begin
        state_next = state_reg;
        det_next = det_reg;
        cls_next = cls_reg;
        dual_load_next = dual_load_reg;
        pwr_next = pwr_reg;
        cut_next = cut_reg;
        lim_next = lim_reg;
        disc_next = disc_reg;
        // Type 2 behaviour from the 25.5W level up
        sec_next = (lvl_reg != pse_pkg::LVL_13W);
        case (state_reg)
            pse_pkg::ST_IDLE: begin
                pwr_next = 1'b0;
                det_next = pse_pkg::DET_UNKNOWN;
                if (run) state_next = pse_pkg::ST_DETECT;
            end
            pse_pkg::ST_DETECT: begin
                if (meas_done) begin
                    det_next = det_now;
                    // Both halves of a dual load measure together
                    if (det_ok(det_now, leg_reg, dual_reg)) begin
                        state_next = pse_pkg::ST_CLASSIFY;
                        dual_load_next = dual_reg &&
                            det_now == pse_pkg::DET_RES_LOW;
                    end
                end
            end
            pse_pkg::ST_CLASSIFY: begin
                if (class_done) begin
                    cls_next = cls_eff;
                    // A dual load needs class 4 unless level is custom, else start over
                    if (dual_load_reg && class_result != pse_pkg::CLS_4
                        && lvl_reg != pse_pkg::LVL_CUSTOM) begin
                        state_next = pse_pkg::ST_IDLE;
                        dual_load_next = 1'b0;
                    end else begin
                        state_next = pse_pkg::ST_POWERED;
                        pwr_next = 1'b1;
                        cut_next = pick_thr(cls_eff, lvl_reg,
                            dual_load_reg, pse_pkg::CUT_CLS_LOW,
                            pse_pkg::CUT_CLS_4, pse_pkg::CUT_CUSTOM);
                        lim_next = pick_thr(cls_eff, lvl_reg,
                            dual_load_reg, pse_pkg::LIM_CLS_LOW,
                            pse_pkg::LIM_CLS_4, pse_pkg::LIM_CUSTOM);
                        disc_next = pse_pkg::DISC_CLS_4;
                    end
                end
            end
            pse_pkg::ST_POWERED: begin
                if (fault_cutoff || fault_limit) begin
                    state_next = pse_pkg::ST_IDLE;
                    pwr_next = 1'b0;
                end else if (load_disconnect) begin
                    state_next = pse_pkg::ST_IDLE;
                    pwr_next = 1'b0;
                end
            end
            default: begin
                state_next = pse_pkg::ST_IDLE;
                pwr_next = 1'b0;
            end
        endcase
        if (!run && state_reg != pse_pkg::ST_IDLE) begin
            state_next = pse_pkg::ST_IDLE;
            pwr_next = 1'b0;
            dual_load_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= pse_pkg::ST_IDLE;
            det_reg <= pse_pkg::DET_UNKNOWN;
            cls_reg <= pse_pkg::CLS_0;
            dual_load_reg <= 1'b0;
            pwr_reg <= 1'b0;
            sec_reg <= 1'b0;
            cut_reg <= pse_pkg::CUT_CLS_LOW;
            lim_reg <= pse_pkg::LIM_CLS_LOW;
            disc_reg <= pse_pkg::DISC_CLS_4;
        end else if (ce) begin
            state_reg <= state_next;
            det_reg <= det_next;
            cls_reg <= cls_next;
            dual_load_reg <= dual_load_next;
            pwr_reg <= pwr_next;
            sec_reg <= sec_next;
            cut_reg <= cut_next;
            lim_reg <= lim_next;
            disc_reg <= disc_next;
        end
    end

    assign port_power_on = pwr_reg;
    assign led_oe = pwr_reg;
    assign led_out = 1'b0 & pwr_reg;
    assign second_event_enable = sec_reg;
    assign midspan_timing = mid_reg;
    assign overcurrent_cutoff_threshold = cut_reg;
    assign current_limit_threshold = lim_reg;
    assign disconnect_threshold = disc_reg;

    // ****************
    // APB slave
    // ****************
    logic [31:0] rd_reg, rd_next, st_word;
    logic rdy_reg, rdy_next, err_reg, err_next;
    logic hit;

    always_comb begin
        st_word = 32'h0000_0000;
        st_word[pse_pkg::ST_POWER_BIT] = pwr_reg;
        st_word[pse_pkg::ST_MID_BIT] = mid_reg;
        st_word[pse_pkg::ST_LEG_BIT] = leg_reg;
        st_word[pse_pkg::ST_DUAL_BIT] = dual_load_reg;
        st_word[pse_pkg::ST_LVL_LSB +: 3] = lvl_reg;
        st_word[pse_pkg::ST_CLS_LSB +: 3] = cls_reg;
        st_word[pse_pkg::ST_DET_LSB +: 3] = det_reg;
        st_word[pse_pkg::ST_STATE_LSB +: 4] = state_reg;
        st_word[pse_pkg::ST_HOLD_BIT] = hold_reg;
        hit = paddr == pse_pkg::CTRL_OFF || paddr == pse_pkg::STATUS_OFF
            || paddr == pse_pkg::THRESH_OFF;
        en_next = en_reg;
        rd_next = rd_reg;
        rdy_next = 1'b0;
        err_next = 1'b0;
        if (psel && !penable) begin
            rdy_next = 1'b1;
            err_next = !hit;
            rd_next = 32'h0000_0000;
            case (paddr)
                pse_pkg::CTRL_OFF: rd_next[pse_pkg::CTRL_EN_BIT] = en_reg;
                pse_pkg::STATUS_OFF: rd_next = st_word;
                pse_pkg::THRESH_OFF: begin
                    rd_next[pse_pkg::TH_CUT_LSB +: 9] = cut_reg;
                    rd_next[pse_pkg::TH_LIM_LSB +: 9] = lim_reg;
                    rd_next[pse_pkg::TH_DISC_LSB +: 10] = disc_reg;
                end
                default: rd_next = 32'h0000_0000;
            endcase
        end
        if (psel && penable && rdy_reg && pwrite
            && paddr == pse_pkg::CTRL_OFF)
            en_next = pwdata[pse_pkg::CTRL_EN_BIT];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            en_reg <= pse_pkg::CTRL_EN_RST;
            rd_reg <= 32'h0000_0000;
            rdy_reg <= 1'b0;
            err_reg <= 1'b0;
        end else if (ce) begin
            en_reg <= en_next;
            rd_reg <= rd_next;
            rdy_reg <= rdy_next;
            err_reg <= err_next;
        end
    end

    assign prdata = rd_reg;
    assign pready = rdy_reg;
    assign pslverr = err_reg;

    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_strap_frozen: assert property (
        !cfg_load_reg |=> $stable(lvl_reg) && $stable(leg_reg)
            && $stable(dual_reg) && $stable(mid_reg))
        else $error("strap changed outside reset exit");
    a_filter_len: assert property (
        $rose(hold_reg) |-> $past(low_cnt_reg) == FILT_LAST
            && !$past(reset_pin_n))
        else $error("reset filter released early");
    a_fault_off: assert property (
        ce && state_reg == pse_pkg::ST_POWERED
            && (fault_cutoff || fault_limit) |=> !port_power_on)
        else $error("fault did not drop power");
    a_disc_off: assert property (
        ce && pwr_reg && load_disconnect |=> !port_power_on
            && state_reg == pse_pkg::ST_IDLE)
        else $error("disconnect did not drop power");
    a_good_class: assert property (
        ce && run && state_reg == pse_pkg::ST_DETECT && meas_done
            && det_now == pse_pkg::DET_GOOD
            |=> state_reg == pse_pkg::ST_CLASSIFY)
        else $error("good detection not classified");
    a_strict_valid: assert property (
        ce && state_reg == pse_pkg::ST_DETECT && meas_done && !leg_reg
            && !dual_reg && det_now != pse_pkg::DET_GOOD
            |=> state_reg != pse_pkg::ST_CLASSIFY)
        else $error("invalid detection accepted");
    a_demote4: assert property (
        ce && state_reg == pse_pkg::ST_CLASSIFY && class_done
            && lvl_reg == pse_pkg::LVL_13W
            && class_result == pse_pkg::CLS_4 |=> cls_reg == pse_pkg::CLS_0
            && !second_event_enable)
        else $error("class 4 not demoted at lowest level");
    a_dual_thr: assert property (
        $rose(pwr_reg) && dual_load_reg
            && lvl_reg != pse_pkg::LVL_CUSTOM
            |-> cut_reg == {pse_pkg::CUT_CLS_4[7:0], 1'b0}
            && disc_reg == pse_pkg::DISC_CLS_4)
        else $error("dual load thresholds wrong");
    a_led_on: assert property (
        state_reg == pse_pkg::ST_POWERED |-> led_oe && !led_out)
        else $error("indicator not pulled low");
    c_powered: cover property ($rose(pwr_reg));
    c_dual: cover property ($rose(pwr_reg) && dual_load_reg);
    c_legacy: cover property ($rose(pwr_reg) && leg_reg
        && det_reg == pse_pkg::DET_CAP_HIGH);
    c_filter: cover property ($rose(hold_reg));
endmodule : pse_ctrl
`default_nettype wire

// >>> tb/pd_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Powered device front end: detection and class answers
// ****************
module pd_model (
    input wire logic sys_clk,
    output logic meas_done,
    output logic [15:0] signature_resistance,
    output logic load_capacitance_high,
    output logic port_voltage_high,
    output logic class_done,
    output logic [2:0] class_result
);
    initial begin
        meas_done = 1'b0;
        signature_resistance = 16'h0000;
        load_capacitance_high = 1'b0;
        port_voltage_high = 1'b0;
        class_done = 1'b0;
        class_result = 3'h0;
    end
    // Data inverted after the valid pulse, so late sampling shows up
    task automatic measure(input logic [15:0] r, input logic c,
            input logic v, input int dly);
        repeat (dly + 1) @(posedge sys_clk);
        meas_done <= 1'b1;
        signature_resistance <= r;
        load_capacitance_high <= c;
        port_voltage_high <= v;
        @(posedge sys_clk);
        meas_done <= 1'b0;
        signature_resistance <= ~r;
        load_capacitance_high <= ~c;
        port_voltage_high <= ~v;
    endtask : measure
    task automatic classify(input logic [2:0] k, input int dly);
        repeat (dly + 1) @(posedge sys_clk);
        class_done <= 1'b1;
        class_result <= k;
        @(posedge sys_clk);
        class_done <= 1'b0;
        class_result <= ~k;
    endtask : classify
endmodule : pd_model
`default_nettype wire

// >>> tb/test_poe_pse_config_and_detect_qualify.sv
`timescale 1ns/1ps
`default_nettype none
module test_poe_pse_config_and_detect_qualify;
    // ****************
    // Signals
    // ****************
    logic sys_clk = 1'b0;
    logic rst_n, reset_pin_n, midspan_select, legacy_select;
    logic two_signature_select, fault_cutoff, fault_limit, load_disconnect;
    logic [2:0] power_level_select;
    logic psel, penable, pwrite, pready, pslverr, er, ce;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic port_power_on, second_event_enable, midspan_timing;
    logic led_out, led_oe, meas_done, load_capacitance_high;
    logic port_voltage_high, class_done;
    logic [15:0] signature_resistance;
    logic [2:0] class_result;
    logic [8:0] overcurrent_cutoff_threshold, current_limit_threshold;
    logic [9:0] disconnect_threshold;
    int fail_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    localparam logic [31:0] M_ST = 32'h000f_0000;
    localparam logic [31:0] M_DET = 32'h0000_7000;
    localparam logic [31:0] M_CLS = 32'h0000_0701;
    localparam logic [31:0] M_CFG = 32'h0000_007f;
    // Resistances just past each bin edge, then two mid-range for cap and voltage
    logic [15:0] res_tab [6] = '{16'h095f, 16'h4267, 16'h7149, 16'hc351,
        16'h61a8, 16'h61a8};
    logic [2:0] det_tab [6] = '{pse_pkg::DET_SHORT, pse_pkg::DET_RES_LOW,
        pse_pkg::DET_RES_HIGH, pse_pkg::DET_OPEN, pse_pkg::DET_CAP_HIGH,
        pse_pkg::DET_VOLT_OUT};

    always #10 sys_clk = ~sys_clk;

    pse_ctrl pse_ctrl_i (
        .sys_clk, .rst_n, .ce, .reset_pin_n, .midspan_select,
        .legacy_select, .two_signature_select, .power_level_select,
        .meas_done, .signature_resistance, .load_capacitance_high,
        .port_voltage_high, .class_done, .class_result, .fault_cutoff,
        .fault_limit, .load_disconnect, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .port_power_on,
        .second_event_enable, .midspan_timing, .overcurrent_cutoff_threshold,
        .current_limit_threshold, .disconnect_threshold, .led_out, .led_oe
    );
    pd_model pd_model_i (
        .sys_clk, .meas_done, .signature_resistance, .load_capacitance_high,
        .port_voltage_high, .class_done, .class_result
    );

    // ****************
    // Tasks
    // ****************
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
            input logic [31:0] wd);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1)
            @(posedge sys_clk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, pse_pkg::STATUS_OFF, 32'h0);
        chk(rd & m, e);
    endtask : st
    task automatic thr(input logic [8:0] c, input logic [8:0] l);
        chk({4'h0, overcurrent_cutoff_threshold, current_limit_threshold,
            disconnect_threshold}, {4'h0, c, l, pse_pkg::DISC_CLS_4});
    endtask : thr
    task automatic boot(input logic m, input logic l, input logic d,
            input logic [2:0] p);
        @(posedge sys_clk);
        rst_n <= 1'b0;
        midspan_select <= m;
        legacy_select <= l;
        two_signature_select <= d;
        power_level_select <= p;
        repeat (12) @(posedge sys_clk);
        chk({31'h0, port_power_on}, 32'h0);
        thr(pse_pkg::CUT_CLS_LOW, pse_pkg::LIM_CLS_LOW);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : boot
    task automatic stop(input logic [1:0] k);
        @(posedge sys_clk);
        fault_cutoff <= (k == 2'd0);
        fault_limit <= (k == 2'd1);
        load_disconnect <= (k == 2'd2);
        @(posedge sys_clk);
        fault_cutoff <= 1'b0;
        fault_limit <= 1'b0;
        load_disconnect <= 1'b0;
        @(posedge sys_clk);
        chk({30'h0, port_power_on, led_oe}, 32'h0);
    endtask : stop
    function automatic logic [31:0] stf(input pse_pkg::port_state_t s);
        return {12'h0, s, 16'h0};
    endfunction : stf
    function automatic logic [31:0] sc(input logic [2:0] k);
        return {21'h0, k, 8'h01};
    endfunction : sc

    // Hang guard, far above the few hundred cycles the run needs
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        {rst_n, psel, penable, pwrite, fault_cutoff, fault_limit} = '0;
        {load_disconnect, midspan_select, legacy_select} = '0;
        two_signature_select = 1'b0;
        power_level_select = 3'h0;
        reset_pin_n = 1'b1;
        ce = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        boot(1'b1, 1'b0, 1'b0, 3'h1);
        st(M_DET | M_ST, stf(pse_pkg::ST_DETECT));
        st(M_CFG, 32'h0000_0012);
        chk({30'h0, second_event_enable, midspan_timing}, 32'h3);
        midspan_select <= 1'b0;
        legacy_select <= 1'b1;
        two_signature_select <= 1'b1;
        power_level_select <= 3'h0;
        st(M_CFG, 32'h0000_0012);
        chk({31'h0, midspan_timing}, 32'h1);
        apb(1'b0, pse_pkg::CTRL_OFF, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 8'h0c, 32'h0);
        chk({rd[30:0], er}, 32'h1);
        for (int i = 0; i < 6; i++) begin
            pd_model_i.measure(res_tab[i], i == 4, i == 5, i);
            st(M_DET | M_ST, stf(pse_pkg::ST_DETECT)
                | {17'h0, det_tab[i], 12'h0});
        end
        pd_model_i.measure(16'h4268, 1'b0, 1'b0, 0);
        st(M_DET | M_ST, stf(pse_pkg::ST_CLASSIFY) | 32'h4000);
        pd_model_i.classify(3'h3, 5);
        st(M_ST | M_CLS, stf(pse_pkg::ST_POWERED) | sc(3'h3));
        chk({30'h0, led_oe, led_out}, 32'h2);
        thr(pse_pkg::CUT_CLS_LOW, pse_pkg::LIM_CLS_LOW);
        reset_pin_n <= 1'b0;
        repeat (100) @(posedge sys_clk);
        reset_pin_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, port_power_on}, 32'h1);
        stop(2'd0);
        pd_model_i.measure(16'h7148, 1'b0, 1'b0, 0);
        pd_model_i.classify(3'h4, 0);
        st(M_ST | M_CLS, stf(pse_pkg::ST_POWERED) | sc(3'h4));
        thr(pse_pkg::CUT_CLS_4, pse_pkg::LIM_CLS_4);
        stop(2'd1);
        pd_model_i.measure(16'h61a8, 1'b0, 1'b0, 0);
        pd_model_i.classify(3'h2, 0);
        stop(2'd2);
        two_signature_select <= 1'b0;
        reset_pin_n <= 1'b0;
        repeat (230) @(posedge sys_clk);
        st(M_ST | 32'h0010_0001, stf(pse_pkg::ST_IDLE) | 32'h0010_0000);
        reset_pin_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        st(M_CFG, 32'h0000_0004);
        chk({31'h0, second_event_enable}, 32'h0);
        pd_model_i.measure(16'h2710, 1'b0, 1'b0, 0);
        st(M_ST, stf(pse_pkg::ST_CLASSIFY));
        pd_model_i.classify(3'h4, 0);
        st(M_CLS, sc(3'h0));
        stop(2'd0);
        pd_model_i.measure(16'h61a8, 1'b1, 1'b0, 0);
        pd_model_i.classify(3'h3, 0);
        st(M_CLS, sc(3'h0));
        // Dual load only with the level at 52.7W or more; the code accepts it at any level
        boot(1'b0, 1'b0, 1'b1, 3'h3);
        pd_model_i.measure(16'h2710, 1'b0, 1'b0, 0);
        st(M_ST, stf(pse_pkg::ST_CLASSIFY));
        pd_model_i.classify(3'h4, 0);
        st(M_CFG, 32'h0000_0039);
        thr(pse_pkg::CUT_CLS_4 << 1, pse_pkg::LIM_CLS_4 << 1);
        boot(1'b0, 1'b0, 1'b0, 3'h6);
        pd_model_i.measure(16'h61a8, 1'b0, 1'b0, 3);
        pd_model_i.classify(3'h2, 0);
        st(M_CFG, 32'h0000_0061);
        thr(pse_pkg::CUT_CUSTOM, pse_pkg::LIM_CUSTOM);
        ce <= 1'b0;
        fault_limit <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({31'h0, port_power_on}, 32'h1);
        fault_limit <= 1'b0;
        ce <= 1'b1;
        apb(1'b1, pse_pkg::CTRL_OFF, 32'h0);
        apb(1'b0, pse_pkg::CTRL_OFF, 32'h0);
        chk({rd[30:0], port_power_on}, 32'h0);
        give_verdict();
    end
endmodule : test_poe_pse_config_and_detect_qualify
`default_nettype wire
